//--- logic/rdrv_pkg.sv
`default_nettype none
package rdrv_pkg;
  localparam int NUM_LANES     = 4;
  localparam int CLK_PERIOD_NS = 10;
  localparam int PULSE_NS      = 100;
  localparam int RETRY_NS      = 200;
  // least times, rounded up to whole cycles
  localparam int PULSE_CYC     = (PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int RETRY_CYC     = (RETRY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CNT_W         = 8;
  localparam int RETRY_MAX     = 3;
  localparam int RETRY_W       = 2;
  localparam int SYNC_W        = 16;

  localparam logic [31:0] ADDR_CTRL   = 32'h0000_0000;
  localparam logic [31:0] ADDR_STATUS = 32'h0000_0004;
  localparam int CTRL_TRIG_BIT   = 0;
  localparam int ST_DET_LSB      = 0;
  localparam int ST_PROBE_LSB    = 4;
  localparam int ST_BUSY_BIT     = 8;
  localparam int ST_EN_BIT       = 9;
  localparam int ST_LP_BIT       = 10;
  localparam int ST_BOOST_LSB    = 11;
  localparam int ST_DEEMPH_LSB   = 13;
  localparam int ST_SWING_BIT    = 15;

  typedef enum logic [1:0] {
    RDRV_LVL_0DB   = 2'h0,
    RDRV_LVL_3P5DB = 2'h1,
    RDRV_LVL_6DB   = 2'h2
  } rdrv_level_e;

  // upper select bit wins regardless of the lower one
  function automatic rdrv_level_e rdrv_decode_level(input logic hi, input logic lo);
    if (hi)
      return RDRV_LVL_6DB;
    else if (lo)
      return RDRV_LVL_3P5DB;
    else
      return RDRV_LVL_0DB;
  endfunction : rdrv_decode_level
endpackage : rdrv_pkg
`default_nettype wire

//--- logic/rdrv_lane_if.sv
`timescale 1ns/1ps
`default_nettype none
interface rdrv_lane_if;
  logic start;
  logic clear;
  logic active;
  logic others_found;
  logic rx_sense;
  logic detected;
  logic probing;
  logic busy;
  modport ctl  (output start, clear, active, others_found, rx_sense, input detected, probing, busy);
  modport lane (input start, clear, active, others_found, rx_sense, output detected, probing, busy);
endinterface : rdrv_lane_if
`default_nettype wire

//--- logic/rdrv_sync.sv
`timescale 1ns/1ps
`default_nettype none
module rdrv_sync #(
  parameter int W = rdrv_pkg::SYNC_W
) (
  // clock and reset
  input  wire logic         hclk,
  input  wire logic         hresetn,
  // pins in, filtered levels out
  input  wire logic [W-1:0] din,
  output logic      [W-1:0] dout
);
  import rdrv_pkg::*;

  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
    logic [W-1:0] s3;
    logic [W-1:0] out;
  } rdrv_sync_s;

  rdrv_sync_s q;
  rdrv_sync_s next_q;

  always_comb
  begin
    next_q     = q;
    next_q.s1  = din;
    next_q.s2  = q.s1;
    next_q.s3  = q.s2;
    // a change is taken only once stages two and three agree
    next_q.out = (~(q.s2 ^ q.s3) & q.s2) | ((q.s2 ^ q.s3) & q.out); // [R19]
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      q <= '0; // [R18]
    else
      q <= next_q;
  end

  assign dout = q.out;
endmodule : rdrv_sync
`default_nettype wire

//--- logic/rdrv_lane_det.sv
`timescale 1ns/1ps
`default_nettype none
module rdrv_lane_det #(
  parameter int PULSE_LEN = rdrv_pkg::PULSE_CYC,
  parameter int RETRY_LEN = rdrv_pkg::RETRY_CYC,
  parameter int MAX_RETRY = rdrv_pkg::RETRY_MAX
) (
  // clock and reset
  input  wire logic  hclk,
  input  wire logic  hresetn,
  // control side
  rdrv_lane_if.lane  lk
);
  import rdrv_pkg::*;

  typedef enum logic [4:0] {
    LN_IDLE  = 5'h01,
    LN_PULSE = 5'h02,
    LN_WAIT  = 5'h04,
    LN_FOUND = 5'h08,
    LN_STOP  = 5'h10
  } rdrv_lane_st_e;

  typedef struct packed {
    rdrv_lane_st_e      st;
    logic [CNT_W-1:0]   cnt;
    logic [RETRY_W-1:0] retries;
    logic               detected;
  } rdrv_lane_s;

  rdrv_lane_s q;
  rdrv_lane_s next_q;

  always_comb
  begin
    next_q = q;
    unique case (q.st)
      LN_IDLE, LN_FOUND, LN_STOP:
        next_q.cnt = '0;
      LN_PULSE:
        if (q.cnt == CNT_W'(PULSE_LEN - 1)) // [R17]
        begin
          next_q.cnt = '0;
          if (lk.rx_sense)
          begin
            next_q.st       = LN_FOUND;
            next_q.detected = 1'b1; // [R19]
          end
          else
            next_q.st = LN_WAIT;
        end
        else
          next_q.cnt = q.cnt + 1'b1;
      LN_WAIT:
        if (q.cnt == CNT_W'(RETRY_LEN - 1)) // [R17]
        begin
          next_q.cnt = '0;
          if (!lk.others_found)
            next_q.st = LN_PULSE; // [R5]
          else if (q.retries == RETRY_W'(MAX_RETRY))
            next_q.st = LN_STOP; // [R6]
          else
          begin
            next_q.retries = q.retries + 1'b1; // [R6]
            next_q.st      = LN_PULSE;
          end
        end
        else
          next_q.cnt = q.cnt + 1'b1;
    endcase
    if (lk.start)
    begin
      next_q.st       = LN_PULSE;
      next_q.cnt      = '0;
      next_q.retries  = '0;
      next_q.detected = 1'b0;
    end
    // disabled lanes forget everything so a new sequence starts clean
    if (lk.clear || !lk.active) // [R20] [R10]
    begin
      next_q.st       = LN_IDLE;
      next_q.cnt      = '0;
      next_q.retries  = '0;
      next_q.detected = 1'b0;
    end
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      q    <= '0;
      q.st <= LN_IDLE;
    end
    else
      q <= next_q;
  end

  assign lk.detected = q.detected;
  assign lk.probing  = (q.st == LN_PULSE);
  assign lk.busy     = (q.st == LN_PULSE) || (q.st == LN_WAIT);

  logic [CNT_W-1:0] plen;
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      plen <= '0;
    else
      plen <= lk.probing ? plen + 1'b1 : '0;
  end

  property p_pulse_len;
    @(posedge hclk) disable iff (!hresetn)
      $fell(lk.probing) && $past(lk.active && !lk.clear && !lk.start) |-> plen == CNT_W'(PULSE_LEN);
  endproperty
  a_pulse_len: assert property (p_pulse_len) else $error("probe pulse length wrong"); // [R17]

  property p_giveup;
    @(posedge hclk) disable iff (!hresetn)
      $rose(q.st == LN_STOP) |-> q.retries == RETRY_W'(MAX_RETRY) && $past(lk.others_found);
  endproperty
  a_giveup: assert property (p_giveup) else $error("lane stopped before its retries were used"); // [R6]

  property p_unlimited;
    @(posedge hclk) disable iff (!hresetn)
      q.st == LN_WAIT && !lk.others_found |=> q.st != LN_STOP;
  endproperty
  a_unlimited: assert property (p_unlimited) else $error("lane stopped while no receiver was found"); // [R5]

  property p_latch;
    @(posedge hclk) disable iff (!hresetn)
      lk.detected && !lk.clear && lk.active && !lk.start |=> lk.detected;
  endproperty
  a_latch: assert property (p_latch) else $error("detected flag dropped"); // [R19]

  property p_clear;
    @(posedge hclk) disable iff (!hresetn)
      lk.clear |=> !lk.detected && q.retries == '0 && !lk.busy;
  endproperty
  a_clear: assert property (p_clear) else $error("clear did not reset lane"); // [R20]
endmodule : rdrv_lane_det
`default_nettype wire

//--- logic/rdrv_ctrl.sv
// What this block does
// [R1] four identical lanes, each with own receiver and idle detection
// [R2] enable high at power-up starts receiver detection automatically
// [R3] trigger rising edge with enable high starts detection; otherwise none
// [R4] while detecting, stay in standby with lane outputs off
// [R5] with no receiver found anywhere, each lane retries forever
// [R6] once one lane finds a receiver, others retry at most three times
// [R7] a detected lane gets its driver and idle detection enabled
// [R8] board logic should pulse enable low after a slow supply ramp
// [R9] enabled lane squelches below idle threshold, drives above it
// [R10] power-save: lanes 1-3 detection off, they follow lane 0
// [R11] normal mode: every lane detects independently
// [R12] power-save select high is power-save, low is normal
// [R13] enable low is standby with outputs off, high is normal
// [R14] boost select: 00 none, 01 3.5 dB, upper bit 6 dB
// [R15] deemphasis select: 00 none, 01 3.5 dB, upper bit 6 dB
// [R16] swing select 0 full swing, 1 reduced swing
// [R17] probe pulse about 100 ns, retry interval about 200 ns
// [R18] undriven inputs read low: standby, no boost, full swing, normal
// [R19] inputs synchronised, trigger edge detected, per-lane retry count and flag
// [R20] enable falling clears all flags and retry counts
`timescale 1ns/1ps
`default_nettype none
module rdrv_ctrl (
  // clock and reset
  input  wire logic                           hclk,
  input  wire logic                           hresetn,
  // ahb-lite slave
  input  wire logic                           hsel,
  input  wire logic [31:0]                    haddr,
  input  wire logic [1:0]                     htrans,
  input  wire logic                           hwrite,
  input  wire logic [2:0]                     hsize,
  input  wire logic [31:0]                    hwdata,
  input  wire logic                           hready,
  output logic      [31:0]                    hrdata,
  output logic                                hreadyout,
  output logic                                hresp,
  // static control pins
  input  wire logic                           dev_enable,
  input  wire logic                           detect_trigger_in,
  input  wire logic                           low_power_sel,
  input  wire logic                           swing_reduce_sel,
  input  wire logic                           rx_boost_sel_hi,
  input  wire logic                           rx_boost_sel_lo,
  input  wire logic                           tx_deemph_sel_hi,
  input  wire logic                           tx_deemph_sel_lo,
  // analog sense per lane
  input  wire logic [rdrv_pkg::NUM_LANES-1:0] rx_sense,
  input  wire logic [rdrv_pkg::NUM_LANES-1:0] idle_below,
  // analog settings
  output rdrv_pkg::rdrv_level_e               rx_boost_level,
  output rdrv_pkg::rdrv_level_e               tx_deemph_level,
  output logic                                swing_reduced,
  output logic                                standby,
  // lane controls
  output logic      [rdrv_pkg::NUM_LANES-1:0] lane_drive_en,
  output logic      [rdrv_pkg::NUM_LANES-1:0] lane_squelch,
  output logic      [rdrv_pkg::NUM_LANES-1:0] idle_det_en,
  output logic      [rdrv_pkg::NUM_LANES-1:0] rx_probe
);
  import rdrv_pkg::*;

  typedef struct packed {
    logic                 en_d;
    logic                 trig_d;
    logic                 sw_trig;
    logic                 dphase;
    logic                 dwrite;
    logic                 dctrl;
    logic [31:0]          rdata;
    rdrv_level_e          boost;
    rdrv_level_e          deemph;
    logic                 swing;
    logic                 standby;
    logic [NUM_LANES-1:0] drive_en;
    logic [NUM_LANES-1:0] squelch;
    logic [NUM_LANES-1:0] idle_en;
    logic [NUM_LANES-1:0] probe;
  } rdrv_ctrl_s;

  rdrv_ctrl_s q;
  rdrv_ctrl_s next_q;

  // every pin passes the three-stage filter
  logic [SYNC_W-1:0] pins_s;
  rdrv_sync #(
    .W (SYNC_W)
  ) u_sync (
    .hclk    (hclk),
    .hresetn (hresetn),
    .din     ({dev_enable, detect_trigger_in, low_power_sel, swing_reduce_sel,
                rx_boost_sel_hi, rx_boost_sel_lo, tx_deemph_sel_hi, tx_deemph_sel_lo,
                rx_sense, idle_below}), // [R19]
    .dout    (pins_s)
  );

  logic                 en_s;
  logic                 trig_s;
  logic                 lp_s;
  logic                 swing_s;
  logic                 bhi_s;
  logic                 blo_s;
  logic                 dhi_s;
  logic                 dlo_s;
  logic [NUM_LANES-1:0] rx_s;
  logic [NUM_LANES-1:0] idle_s;
  assign {en_s, trig_s, lp_s, swing_s, bhi_s, blo_s, dhi_s, dlo_s, rx_s, idle_s} = pins_s;

  logic start;
  logic any_busy;
  logic [NUM_LANES-1:0] det;
  logic [NUM_LANES-1:0] probing;
  logic [NUM_LANES-1:0] busy;

  // enable rise covers power-up, since the filtered level leaves reset low
  assign start = (en_s && !q.en_d)
               || (en_s && trig_s && !q.trig_d)
               || (en_s && q.sw_trig); // [R2] [R3]
  assign any_busy = |busy;

  genvar gi;
  generate
    for (gi = 0; gi < NUM_LANES; gi++)
    begin : g_lane
      rdrv_lane_if lk ();
      assign lk.start        = start;
      assign lk.clear        = !en_s; // [R20]
      assign lk.active       = (gi == 0) || !lp_s; // [R10] [R11] [R12]
      assign lk.others_found = |(det & ~(NUM_LANES'(1) << gi)); // [R6]
      assign lk.rx_sense     = rx_s[gi];
      assign det[gi]         = lk.detected;
      assign probing[gi]     = lk.probing;
      assign busy[gi]        = lk.busy;
      rdrv_lane_det u_det ( // [R1]
        .hclk    (hclk),
        .hresetn (hresetn),
        .lk      (lk)
      );
    end
  endgenerate

  // in power-save every lane copies lane 0's detected flag and idle level
  logic [NUM_LANES-1:0] det_eff;
  logic [NUM_LANES-1:0] idle_eff;
  logic [NUM_LANES-1:0] next_drive;
  always_comb
  begin
    for (int i = 0; i < NUM_LANES; i++)
    begin
      det_eff[i]    = lp_s ? det[0] : det[i]; // [R10] [R11]
      idle_eff[i]   = lp_s ? idle_s[0] : idle_s[i];
      next_drive[i] = en_s && !any_busy && det_eff[i]; // [R4] [R7] [R13]
    end
  end

  logic        addr_ok;
  logic [31:0] status_word;
  always_comb
  begin
    addr_ok     = hsel && htrans[1] && hready;
    status_word = '0;
    status_word[ST_DET_LSB +: NUM_LANES]   = det_eff;
    status_word[ST_PROBE_LSB +: NUM_LANES] = probing;
    status_word[ST_BUSY_BIT]               = any_busy;
    status_word[ST_EN_BIT]                 = en_s;
    status_word[ST_LP_BIT]                 = lp_s;
    status_word[ST_BOOST_LSB +: 2]         = q.boost;
    status_word[ST_DEEMPH_LSB +: 2]        = q.deemph;
    status_word[ST_SWING_BIT]              = q.swing;
  end

  always_comb
  begin
    next_q          = q;
    next_q.en_d     = en_s;
    next_q.trig_d   = trig_s; // [R19]
    next_q.boost    = rdrv_decode_level(bhi_s, blo_s); // [R14]
    next_q.deemph   = rdrv_decode_level(dhi_s, dlo_s); // [R15]
    next_q.swing    = swing_s; // [R16]
    next_q.standby  = !en_s || any_busy; // [R4] [R13]
    next_q.drive_en = next_drive;
    next_q.squelch  = next_drive & idle_eff; // [R9]
    next_q.idle_en  = next_drive & (lp_s ? NUM_LANES'(1) : {NUM_LANES{1'b1}}); // [R7] [R10]
    next_q.probe    = probing;
    // write to the trigger bit gives a single-cycle start request
    next_q.sw_trig  = q.dphase && q.dwrite && q.dctrl && hwdata[CTRL_TRIG_BIT];
    next_q.dphase   = addr_ok;
    next_q.dwrite   = addr_ok && hwrite;
    next_q.dctrl    = addr_ok && (haddr == ADDR_CTRL);
    // read data captured at the address phase; unmapped reads give zero
    if (addr_ok && !hwrite && haddr == ADDR_STATUS)
      next_q.rdata = status_word;
    else
      next_q.rdata = '0;
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      q         <= '0; // [R18]
      q.standby <= 1'b1;
    end
    else
      q <= next_q;
  end

  // zero-wait slave, never errors
  assign hreadyout       = 1'b1;
  assign hresp           = 1'b0;
  assign hrdata          = q.rdata;
  assign rx_boost_level  = q.boost;
  assign tx_deemph_level = q.deemph;
  assign swing_reduced   = q.swing;
  assign standby         = q.standby;
  assign lane_drive_en   = q.drive_en;
  assign lane_squelch    = q.squelch;
  assign idle_det_en     = q.idle_en;
  assign rx_probe        = q.probe;

  property p_busy_off;
    @(posedge hclk) disable iff (!hresetn)
      any_busy |=> lane_drive_en == '0 && standby;
  endproperty
  a_busy_off: assert property (p_busy_off) else $error("outputs on during detection"); // [R4]

  property p_en_off;
    @(posedge hclk) disable iff (!hresetn)
      !en_s |=> lane_drive_en == '0 && standby && !any_busy;
  endproperty
  a_en_off: assert property (p_en_off) else $error("outputs on while disabled"); // [R13]

  property p_powerup;
    @(posedge hclk) disable iff (!hresetn)
      en_s && !q.en_d |=> any_busy ##1 rx_probe[0];
  endproperty
  a_powerup: assert property (p_powerup) else $error("enable rise did not start detection"); // [R2]

  property p_trig;
    @(posedge hclk) disable iff (!hresetn)
      en_s && $rose(trig_s) && $past(en_s) |=> probing[0];
  endproperty
  a_trig: assert property (p_trig) else $error("trigger edge did not start detection"); // [R3]

  property p_boost;
    @(posedge hclk) disable iff (!hresetn)
      bhi_s |=> rx_boost_level == RDRV_LVL_6DB;
  endproperty
  a_boost: assert property (p_boost) else $error("boost decode wrong"); // [R14]

  property p_deemph;
    @(posedge hclk) disable iff (!hresetn)
      !dhi_s && dlo_s |=> tx_deemph_level == RDRV_LVL_3P5DB;
  endproperty
  a_deemph: assert property (p_deemph) else $error("deemphasis decode wrong"); // [R15]

  property p_swing;
    @(posedge hclk) disable iff (!hresetn)
      swing_s != $past(swing_s) |=> swing_reduced == $past(swing_s);
  endproperty
  a_swing: assert property (p_swing) else $error("swing select not followed"); // [R16]

  property p_psave;
    @(posedge hclk) disable iff (!hresetn)
      lp_s ##1 lp_s |=> rx_probe[NUM_LANES-1:1] == '0 && idle_det_en[NUM_LANES-1:1] == '0;
  endproperty
  a_psave: assert property (p_psave) else $error("slaved lanes still detecting"); // [R10]

  property p_squelch;
    @(posedge hclk) disable iff (!hresetn)
      lane_drive_en[0] && !lane_squelch[0] |-> !$past(idle_eff[0]);
  endproperty
  a_squelch: assert property (p_squelch) else $error("lane driven while input idle"); // [R9]

  property p_drv_stby;
    @(posedge hclk) disable iff (!hresetn)
      lane_drive_en != '0 |-> !standby;
  endproperty
  a_drv_stby: assert property (p_drv_stby) else $error("driver on in standby"); // [R4]

  property p_drv_en;
    @(posedge hclk) disable iff (!hresetn)
      lane_drive_en != '0 |-> $past(en_s);
  endproperty
  a_drv_en: assert property (p_drv_en) else $error("driver on without enable"); // [R13]

  property p_idle_drv;
    @(posedge hclk) disable iff (!hresetn)
      (idle_det_en & ~lane_drive_en) == '0;
  endproperty
  a_idle_drv: assert property (p_idle_drv) else $error("idle detect on undriven lane"); // [R7]

  property p_sq_drv;
    @(posedge hclk) disable iff (!hresetn)
      (lane_squelch & ~lane_drive_en) == '0;
  endproperty
  a_sq_drv: assert property (p_sq_drv) else $error("squelch on undriven lane"); // [R9]

  property p_norm_idle;
    @(posedge hclk) disable iff (!hresetn)
      !lp_s |=> idle_det_en == lane_drive_en;
  endproperty
  a_norm_idle: assert property (p_norm_idle) else $error("idle detect not per lane"); // [R11]
endmodule : rdrv_ctrl
`default_nettype wire

//--- verification/rdrv_rx_partner.sv
`timescale 1ns/1ps
`default_nettype none
module rdrv_rx_partner (
  // clock
  input  wire logic                           hclk,
  // probes in, senses out
  input  wire logic [rdrv_pkg::NUM_LANES-1:0] rx_probe,
  output logic      [rdrv_pkg::NUM_LANES-1:0] rx_sense,
  output logic      [rdrv_pkg::NUM_LANES-1:0] idle_below,
  // scenario knobs
  input  wire logic [rdrv_pkg::NUM_LANES-1:0] present,
  input  wire logic [rdrv_pkg::NUM_LANES-1:0] idle_in,
  input  wire logic                           slow
);
  import rdrv_pkg::*;
  logic [3:0] age [NUM_LANES] = '{default: 4'h0};
  logic       wobble          = 1'b0;

  // outside a probe the sense line floats: show a changing level, never the last one
  always_ff @(posedge hclk)
  begin
    wobble <= ~wobble;
    for (int i = 0; i < NUM_LANES; i++)
      age[i] <= rx_probe[i] ? ((age[i] == 4'hF) ? age[i] : age[i] + 4'h1) : 4'h0;
  end

  // slow receiver answers 3 cycles into the probe
  always_comb
  begin
    for (int i = 0; i < NUM_LANES; i++)
      rx_sense[i] = (rx_probe[i] && (!slow || age[i] >= 4'h3)) ? present[i] : (wobble ^ i[0]);
  end

  assign idle_below = idle_in;
endmodule : rdrv_rx_partner
`default_nettype wire

//--- verification/tb.sv
`timescale 1ns/1ps
`default_nettype none
module tb;
  import rdrv_pkg::*;
  logic                 hclk              = 1'b0;
  logic                 hresetn           = 1'b0;
  logic                 hsel              = 1'b0;
  logic [31:0]          haddr             = 32'h0;
  logic [1:0]           htrans            = 2'h0;
  logic                 hwrite            = 1'b0;
  logic [2:0]           hsize             = 3'h2;
  logic [31:0]          hwdata            = 32'h0;
  logic                 dev_enable        = 1'b0;
  logic                 detect_trigger_in = 1'b0;
  logic                 low_power_sel     = 1'b0;
  logic                 swing_reduce_sel  = 1'b0;
  logic [1:0]           boost_sel         = 2'h0;
  logic [1:0]           deemph_sel        = 2'h0;
  logic                 slow              = 1'b0;
  logic [NUM_LANES-1:0] present           = 4'h0;
  logic [NUM_LANES-1:0] idle_in           = 4'h0;
  logic [NUM_LANES-1:0] prev              = 4'h0;
  logic [31:0]          hrdata;
  logic                 hreadyout;
  logic                 hresp;
  rdrv_level_e          rx_boost_level;
  rdrv_level_e          tx_deemph_level;
  logic                 swing_reduced;
  logic                 standby;
  logic [NUM_LANES-1:0] lane_drive_en;
  logic [NUM_LANES-1:0] lane_squelch;
  logic [NUM_LANES-1:0] idle_det_en;
  logic [NUM_LANES-1:0] rx_probe;
  logic [NUM_LANES-1:0] rx_sense;
  logic [NUM_LANES-1:0] idle_below;
  logic [31:0]          rd;
  int                   miscompares       = 0;
  int                   compares          = 0;
  int                   cnt [NUM_LANES]   = '{default: 0};
  int                   hi_len            = 0;
  int                   gap_len           = 0;
  int                   last_hi           = 0;
  int                   last_gap          = 0;

  always #5 hclk = ~hclk;

  rdrv_ctrl dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
    .dev_enable(dev_enable), .detect_trigger_in(detect_trigger_in), .low_power_sel(low_power_sel),
    .swing_reduce_sel(swing_reduce_sel), .rx_boost_sel_hi(boost_sel[1]), .rx_boost_sel_lo(boost_sel[0]),
    .tx_deemph_sel_hi(deemph_sel[1]), .tx_deemph_sel_lo(deemph_sel[0]), .rx_sense(rx_sense),
    .idle_below(idle_below), .rx_boost_level(rx_boost_level), .tx_deemph_level(tx_deemph_level),
    .swing_reduced(swing_reduced), .standby(standby), .lane_drive_en(lane_drive_en),
    .lane_squelch(lane_squelch), .idle_det_en(idle_det_en), .rx_probe(rx_probe));

  rdrv_rx_partner u_partner (.hclk(hclk), .rx_probe(rx_probe), .rx_sense(rx_sense), .idle_below(idle_below),
    .present(present), .idle_in(idle_in), .slow(slow));

  task automatic end_sim;
    $display("compares %0d miscompares %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : end_sim

  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    compares++;
    if (g !== e)
    begin
      miscompares++;
      $display("MISMATCH %s expected %0h seen %0h", n, e, g);
    end
  endtask : chk

  function automatic logic [31:0] lvl(input logic [1:0] s);
    return s[1] ? 32'h2 : {31'h0, s[0]};
  endfunction : lvl

  // one cycle, sampled mid-cycle; counts probe starts and lane 0 pulse and gap lengths
  task automatic tick;
    @(negedge hclk);
    for (int i = 0; i < NUM_LANES; i++)
      if (rx_probe[i] && !prev[i])
        cnt[i]++;
    if (rx_probe[0])
      hi_len++;
    else
      gap_len++;
    if (rx_probe[0] && !prev[0])
    begin
      last_gap = gap_len;
      gap_len  = 0;
    end
    if (!rx_probe[0] && prev[0])
    begin
      last_hi = hi_len;
      hi_len  = 0;
    end
    prev = rx_probe;
  endtask : tick

  task automatic run(input int n);
    repeat (n) tick();
  endtask : run

  task automatic clr;
    cnt = '{default: 0};
  endtask : clr

  task automatic wait_done;
    int k;
    run(12);
    for (k = 0; k < 2000 && standby !== 1'b0; k++)
      tick();
    if (standby !== 1'b0)
    begin
      miscompares++;
      $display("MISMATCH detection end expected 0 seen %0h", standby);
      end_sim();
    end
    run(4);
  endtask : wait_done

  task automatic wait_rdy(output logic [31:0] r);
    logic ok;
    ok = 1'b0;
    for (int k = 0; k < 64 && ok !== 1'b1; k++)
    begin
      @(posedge hclk);
      ok = hreadyout;
      r  = hrdata;
    end
    if (ok !== 1'b1)
    begin
      miscompares++;
      $display("MISMATCH hready expected 1 seen %0h", ok);
      end_sim();
    end
  endtask : wait_rdy

  task automatic ahb(input logic wr, input logic [31:0] a, input logic [31:0] wd, output logic [31:0] r);
    @(posedge hclk);
    {hsel, haddr, htrans, hwrite} <= {1'b1, a, 2'h2, wr};
    wait_rdy(r);
    {htrans, hwdata} <= {2'h0, wd};
    wait_rdy(r);
  endtask : ahb

  initial
  begin
    repeat (2) tick();
    chk("reset standby", 32'h1, {31'h0, standby});
    chk("reset drive", 32'h0, {28'h0, lane_drive_en});
    @(posedge hclk);
    hresetn <= 1'b1;
    run(12);
    chk("default standby", 32'h1, {31'h0, standby});
    chk("default probe", 32'h0, {28'h0, rx_probe});
    chk("default swing", 32'h0, {31'h0, swing_reduced});
    for (int k = 0; k < 4; k++)
    begin
      @(posedge hclk);
      {boost_sel, deemph_sel, swing_reduce_sel} <= {k[1:0], ~k[1:0], k[0]};
      run(10);
      chk("boost", lvl(k[1:0]), {30'h0, rx_boost_level});
      chk("deemph", lvl(~k[1:0]), {30'h0, tx_deemph_level});
      chk("swing", {31'h0, k[0]}, {31'h0, swing_reduced});
    end
    // second reset, enable already high: power-up detection
    @(posedge hclk);
    {hresetn, dev_enable, present} <= {1'b0, 1'b1, 4'h1};
    repeat (3) @(posedge hclk);
    hresetn <= 1'b1;
    clr();
    run(20);
    chk("standby busy", 32'h1, {31'h0, standby});
    chk("drive busy", 32'h0, {28'h0, lane_drive_en});
    wait_done();
    chk("lane0 probes", 32'h1, cnt[0]);
    for (int i = 1; i < NUM_LANES; i++)
      chk("limited retries", 1 + RETRY_MAX, cnt[i]);
    chk("drive found", 32'h1, {28'h0, lane_drive_en});
    chk("idle found", 32'h1, {28'h0, idle_det_en});
    @(posedge hclk);
    dev_enable <= 1'b0;
    run(10);
    chk("standby off", 32'h1, {31'h0, standby});
    chk("drive off", 32'h0, {28'h0, lane_drive_en});
    chk("idle off", 32'h0, {28'h0, idle_det_en});
    clr();
    @(posedge hclk);
    detect_trigger_in <= 1'b1;
    run(40);
    chk("no start disabled", 32'h0, cnt[0] + cnt[1] + cnt[2] + cnt[3]);
    // board pulses enable back high, nothing attached
    @(posedge hclk);
    {detect_trigger_in, present, dev_enable} <= {1'b0, 4'h0, 1'b1};
    run(320);
    for (int i = 0; i < NUM_LANES; i++)
      chk("endless retry", 32'h1, {31'h0, cnt[i] > 1 + RETRY_MAX});
    chk("standby search", 32'h1, {31'h0, standby});
    chk("pulse len", PULSE_CYC, last_hi);
    chk("retry gap", RETRY_CYC, last_gap);
    @(posedge hclk);
    present <= 4'hF;
    wait_done();
    chk("drive all", 32'hF, {28'h0, lane_drive_en});
    @(posedge hclk);
    idle_in <= 4'h5;
    run(8);
    chk("squelch", 32'h5, {28'h0, lane_squelch});
    clr();
    @(posedge hclk);
    {idle_in, present, detect_trigger_in} <= {4'h0, 4'h2, 1'b1};
    run(8);
    chk("unsquelch", 32'h0, {28'h0, lane_squelch});
    wait_done();
    chk("lane1 probes", 32'h1, cnt[1]);
    chk("lane3 retries", 1 + RETRY_MAX, cnt[3]);
    chk("drive lane1", 32'h2, {28'h0, lane_drive_en});
    clr();
    run(100);
    chk("held trigger", 32'h0, cnt[0] + cnt[1] + cnt[2] + cnt[3]);
    @(posedge hclk);
    {detect_trigger_in, slow, present} <= {1'b0, 1'b1, 4'hF};
    clr();
    ahb(1'b1, ADDR_CTRL, 32'h1, rd);
    wait_done();
    chk("slow all found", 32'hF, {28'h0, lane_drive_en});
    ahb(1'b0, ADDR_STATUS, 32'h0, rd);
    chk("status", 32'h0000_920F, rd);
    ahb(1'b0, ADDR_CTRL, 32'h0, rd);
    chk("ctrl read", 32'h0, rd);
    ahb(1'b0, 32'h0000_0008, 32'h0, rd);
    chk("unmapped", 32'h0, rd);
    chk("resp", 32'h0, {31'h0, hresp});
    @(posedge hclk);
    {low_power_sel, slow, present} <= {1'b1, 1'b0, 4'h1};
    run(10);
    clr();
    @(posedge hclk);
    detect_trigger_in <= 1'b1;
    wait_done();
    chk("save probes", 32'h0, cnt[1] + cnt[2] + cnt[3]);
    chk("save drive", 32'hF, {28'h0, lane_drive_en});
    chk("save idle", 32'h1, {28'h0, idle_det_en});
    @(posedge hclk);
    idle_in <= 4'h1;
    run(8);
    chk("save squelch", 32'hF, {28'h0, lane_squelch});
    @(posedge hclk);
    idle_in <= 4'hE;
    run(8);
    chk("save follow", 32'h0, {28'h0, lane_squelch});
    end_sim();
  end
endmodule : tb
`default_nettype wire
